// ### simd_alu_pkg.sv
// Purpose: Shared constants and types for the packed add/subtract and test ALU slice.
// Assumes: A 32-bit Avalon-MM slave with byte addressing and one wait state.
// Notes: Offsets, command layout and register indices are local encodings.
package simd_alu_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    localparam logic [ADDR_W-1:0] OFS_FIRST_OPERAND = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_SECOND_OPERAND = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS_WORD = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_ERROR_STATUS = 5'h14;

    localparam int FLAG_N_POS = 31;
    localparam int FLAG_Z_POS = 30;
    localparam int FLAG_C_POS = 29;
    localparam int FLAG_V_POS = 28;
    localparam int ERROR_BIT_POS = 0;
    localparam int COUNT_LSB_POS = 16;
    localparam int COUNT_W = 16;

    localparam logic [3:0] STACK_POINTER_INDEX = 4'hd;
    localparam logic [3:0] PROGRAM_COUNTER_INDEX = 4'hf;

    localparam logic [DATA_W-1:0] OPERAND_RESET = 32'h0000_0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

    typedef enum logic [3:0] {
        op_signed_add_sub_exchange,
        op_signed_sub_add_exchange,
        op_bit_test_and,
        op_equivalence_test_xor,
        op_unsigned_packed_halfword_add,
        op_unsigned_packed_byte_add,
        op_unsigned_add_sub_exchange,
        op_unsigned_sub_add_exchange,
        op_unsigned_halving_halfword_add,
        op_unsigned_halving_byte_add,
        op_unsigned_halving_add_sub_exchange,
        op_unsigned_halving_sub_add_exchange
    } op_type;

    localparam logic [3:0] OP_COUNT = 4'hc;

    typedef struct packed {
        logic [13:0] reserved;
        logic carry_valid;
        logic carry_in;
        logic [3:0] dest_idx;
        logic [3:0] first_idx;
        logic [3:0] second_idx;
        logic [3:0] op_code;
    } cmd_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [BE_W-1:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } av_req_type;

endpackage

// ### simd_halfword_byte_add_sub_test_alu.sv
// Purpose: Packed halfword add/subtract, byte add and bit/equivalence test ALU slice.
// Assumes: Avalon-MM master on mclk_in; every access answers after one wait state.
// Notes: Writing a legal command to the command offset executes one operation on the stored operands.
`timescale 1ns/10ps
module simd_halfword_byte_add_sub_test_alu (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire simd_alu_pkg::av_req_type avalon_in,
    output logic avalon_waitrequest_out,
    output logic [simd_alu_pkg::DATA_W-1:0] avalon_readdata_out,
    output logic [simd_alu_pkg::DATA_W-1:0] result_out,
    output logic [3:0] flags_out
);
    import simd_alu_pkg::*;

    logic ack_reg;
    logic access;
    logic wr_take;
    logic [DATA_W-1:0] readdata_reg;
    logic [DATA_W-1:0] read_mux;
    logic [DATA_W-1:0] first_operand_reg;
    logic [DATA_W-1:0] second_operand_reg;
    logic [DATA_W-1:0] result_reg;
    logic [DATA_W-1:0] last_cmd_reg;
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic error_reg;
    logic error_next;
    logic [COUNT_W-1:0] exec_count_reg;
    cmd_type cmd;
    op_type op;
    logic op_known;
    logic reg_bad;
    logic cmd_write;
    logic cmd_legal;
    logic cmd_illegal;
    logic is_test;
    logic [DATA_W-1:0] alu_res;
    logic [16:0] sum_hi_blo;
    logic [16:0] dif_hi_blo;
    logic [16:0] sum_lo_bhi;
    logic [16:0] dif_lo_bhi;
    logic [16:0] sum_hi_bhi;
    logic [16:0] sum_lo_blo;
    logic [8:0] byte_sum [4];

    // Each halfword lane is formed one bit wider than its operands.
    function automatic logic [16:0] lane16(input logic [15:0] x, input logic [15:0] y,
                                            input logic sub);
        logic [16:0] xe;
        logic [16:0] ye;
        xe = {1'b0, x};
        ye = {1'b0, y};
        lane16 = sub ? (xe - ye) : (xe + ye);
    endfunction

    function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_v,
                                                      input logic [DATA_W-1:0] new_v,
                                                      input logic [BE_W-1:0] be);
        logic [DATA_W-1:0] v;
        v = old_v;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge_bytes = v;
    endfunction

    // One wait state on every access gives the read mux a full cycle.
    assign access = avalon_in.read | avalon_in.write;
    assign avalon_waitrequest_out = access & ~ack_reg;
    assign wr_take = avalon_in.write & ack_reg;
    assign avalon_readdata_out = readdata_reg;
    assign result_out = result_reg;
    assign flags_out = flags_reg;

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
        end
    end

    always_comb begin
        read_mux = '0;
        unique case (avalon_in.address)
            OFS_FIRST_OPERAND: read_mux = first_operand_reg;
            OFS_SECOND_OPERAND: read_mux = second_operand_reg;
            OFS_COMMAND: read_mux = last_cmd_reg;
            OFS_RESULT: read_mux = result_reg;
            OFS_STATUS_WORD: read_mux[FLAG_N_POS -: 4] = flags_reg;
            OFS_ERROR_STATUS: begin
                read_mux[COUNT_LSB_POS +: COUNT_W] = exec_count_reg;
                read_mux[ERROR_BIT_POS] = error_reg;
            end
            default: read_mux = '0;
        endcase
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            readdata_reg <= '0;
        end else if (avalon_in.read & ~ack_reg) begin
            readdata_reg <= read_mux;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            first_operand_reg <= OPERAND_RESET;
        end else if (wr_take && avalon_in.address == OFS_FIRST_OPERAND) begin
            first_operand_reg <= merge_bytes(first_operand_reg, avalon_in.writedata,
                                             avalon_in.byteenable);
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            second_operand_reg <= OPERAND_RESET;
        end else if (wr_take && avalon_in.address == OFS_SECOND_OPERAND) begin
            second_operand_reg <= merge_bytes(second_operand_reg, avalon_in.writedata,
                                              avalon_in.byteenable);
        end
    end

    // Command decode; codes past the last operation are refused.
    assign cmd = cmd_type'(avalon_in.writedata);
    assign op = op_type'(cmd.op_code);
    assign op_known = cmd.op_code < OP_COUNT;
    assign is_test = (op == op_bit_test_and) || (op == op_equivalence_test_xor);
    assign cmd_write = wr_take && (avalon_in.address == OFS_COMMAND);

    always_comb begin
        reg_bad = (cmd.first_idx == STACK_POINTER_INDEX) ||
                  (cmd.first_idx == PROGRAM_COUNTER_INDEX) ||
                  (cmd.second_idx == STACK_POINTER_INDEX) ||
                  (cmd.second_idx == PROGRAM_COUNTER_INDEX);
        if (!is_test) begin
            reg_bad = reg_bad || (cmd.dest_idx == STACK_POINTER_INDEX) ||
                      (cmd.dest_idx == PROGRAM_COUNTER_INDEX);
        end
    end

    assign cmd_legal = cmd_write & op_known & ~reg_bad;
    assign cmd_illegal = cmd_write & ~(op_known & ~reg_bad);

    always_comb begin
        sum_hi_blo = lane16(first_operand_reg[31:16], second_operand_reg[15:0], 1'b0);
        dif_hi_blo = lane16(first_operand_reg[31:16], second_operand_reg[15:0], 1'b1);
        sum_lo_bhi = lane16(first_operand_reg[15:0], second_operand_reg[31:16], 1'b0);
        dif_lo_bhi = lane16(first_operand_reg[15:0], second_operand_reg[31:16], 1'b1);
        sum_hi_bhi = lane16(first_operand_reg[31:16], second_operand_reg[31:16], 1'b0);
        sum_lo_blo = lane16(first_operand_reg[15:0], second_operand_reg[15:0], 1'b0);
        for (int i = 0; i < 4; i++) begin
            byte_sum[i] = {1'b0, first_operand_reg[i*8 +: 8]} +
                          {1'b0, second_operand_reg[i*8 +: 8]};
        end
    end

    always_comb begin
        alu_res = '0;
        unique case (op)
            op_signed_add_sub_exchange: begin
                alu_res[31:16] = sum_hi_blo[15:0];
                alu_res[15:0] = dif_hi_blo[15:0];
            end
            op_signed_sub_add_exchange: begin
                alu_res[31:16] = dif_hi_blo[15:0];
                alu_res[15:0] = sum_lo_bhi[15:0];
            end
            op_bit_test_and: alu_res = first_operand_reg & second_operand_reg;
            op_equivalence_test_xor: alu_res = first_operand_reg ^ second_operand_reg;
            op_unsigned_packed_halfword_add: begin
                alu_res[31:16] = sum_hi_bhi[15:0];
                alu_res[15:0] = sum_lo_blo[15:0];
            end
            op_unsigned_packed_byte_add: begin
                for (int i = 0; i < 4; i++) begin
                    alu_res[i*8 +: 8] = byte_sum[i][7:0];
                end
            end
            op_unsigned_add_sub_exchange: begin
                alu_res[15:0] = dif_lo_bhi[15:0];
                alu_res[31:16] = sum_hi_blo[15:0];
            end
            op_unsigned_sub_add_exchange: begin
                alu_res[15:0] = sum_lo_bhi[15:0];
                alu_res[31:16] = dif_hi_blo[15:0];
            end
            op_unsigned_halving_halfword_add: begin
                alu_res[31:16] = sum_hi_bhi[16:1];
                alu_res[15:0] = sum_lo_blo[16:1];
            end
            op_unsigned_halving_byte_add: begin
                for (int i = 0; i < 4; i++) begin
                    alu_res[i*8 +: 8] = byte_sum[i][8:1];
                end
            end
            op_unsigned_halving_add_sub_exchange: begin
                alu_res[31:16] = sum_hi_blo[16:1];
                alu_res[15:0] = dif_lo_bhi[16:1];
            end
            op_unsigned_halving_sub_add_exchange: begin
                alu_res[31:16] = dif_hi_blo[16:1];
                alu_res[15:0] = sum_lo_bhi[16:1];
            end
            // Codes past the last operation reach here whenever writedata carries them, with or without a bus write.
            default: alu_res = '0;
        endcase
    end

    // A test writes no destination, so the result holds its last value.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            result_reg <= OPERAND_RESET;
        end else if (cmd_legal && !is_test) begin
            result_reg <= alu_res;
        end
    end

    always_comb begin
        flags_next = flags_reg;
        if (wr_take && avalon_in.address == OFS_STATUS_WORD && avalon_in.byteenable[3]) begin
            flags_next = avalon_in.writedata[FLAG_N_POS -: 4];
        end
        if (cmd_legal && is_test) begin
            flags_next[3] = alu_res[31];
            flags_next[2] = (alu_res == '0);
            if (cmd.carry_valid) begin
                flags_next[1] = cmd.carry_in;
            end
            flags_next[0] = flags_reg[0];
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // A refused command and a clear cannot share an edge, but set still wins.
    assign error_next = cmd_illegal |
        (error_reg & ~(wr_take && avalon_in.address == OFS_ERROR_STATUS &&
                       avalon_in.byteenable[0] && avalon_in.writedata[ERROR_BIT_POS]));

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            error_reg <= 1'b0;
        end else begin
            error_reg <= error_next;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            last_cmd_reg <= OPERAND_RESET;
        end else if (cmd_write) begin
            last_cmd_reg <= avalon_in.writedata;
        end
    end

    // The counter wraps; software compares two readings, not absolute values.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            exec_count_reg <= COUNT_RESET;
        end else if (cmd_legal) begin
            exec_count_reg <= exec_count_reg + 16'h0001;
        end
    end

endmodule

// ### alu_host_model.sv
// Purpose: Host-side bus master that issues register accesses to the ALU slice.
// Assumes: One clock; requests change only by non-blocking assignment after a rising edge.
// Notes: A request is held until waitrequest is sampled low; the bench watchdog ends a hang.
`timescale 1ns/10ps
module alu_host_model
    import simd_alu_pkg::*;
(
    input wire logic mclk_in,
    input wire logic wait_in,
    input wire logic [simd_alu_pkg::DATA_W-1:0] rdata_in,
    output simd_alu_pkg::av_req_type req_out
);
    initial req_out = '0;

    // One idle edge follows each release so that no edge sees the request assigned twice.
    task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] data, input logic [BE_W-1:0] be,
        output logic [DATA_W-1:0] rd);
        req_out <= '{read: !wr, write: wr, address: addr, byteenable: be, writedata: data};
        @(posedge mclk_in);
        while (wait_in !== 1'b0) begin
            @(posedge mclk_in);
        end
        rd = rdata_in;
        req_out <= '0;
        @(posedge mclk_in);
    endtask
endmodule

// ### alu_slice_checker.sv
// Purpose: Concurrent checks on command results and flags of the ALU slice.
// Assumes: Operands are shadowed from accepted bus writes with byteenable honoured.
// Notes: A command takes effect at the edge where its write sees waitrequest low.
`timescale 1ns/10ps
module alu_slice_checker
    import simd_alu_pkg::*;
(
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire simd_alu_pkg::av_req_type avalon_in,
    input wire logic avalon_waitrequest_out,
    input wire logic [simd_alu_pkg::DATA_W-1:0] avalon_readdata_out,
    input wire logic [simd_alu_pkg::DATA_W-1:0] result_out,
    input wire logic [3:0] flags_out
);
    logic [DATA_W-1:0] a_sh, b_sh, half_sum, byte_sum;
    logic [1:0] and_nz, xor_nz;
    logic fire, legal, is_test, take, carry_bit;
    cmd_type c;
    assign c = cmd_type'(avalon_in.writedata);
    assign take = avalon_in.write && !avalon_waitrequest_out;
    assign fire = take && avalon_in.address == OFS_COMMAND;
    assign is_test = c.op_code == 4'h2 || c.op_code == 4'h3;
    assign legal = c.op_code < OP_COUNT && c.first_idx != 4'hd && c.first_idx != 4'hf
        && c.second_idx != 4'hd && c.second_idx != 4'hf
        && (is_test || (c.dest_idx != 4'hd && c.dest_idx != 4'hf));
    assign carry_bit = c.carry_in;
    assign and_nz = {a_sh[31] & b_sh[31], (a_sh & b_sh) == 32'h0000_0000};
    assign xor_nz = {a_sh[31] ^ b_sh[31], (a_sh ^ b_sh) == 32'h0000_0000};
    assign half_sum = {a_sh[31:16] + b_sh[31:16], a_sh[15:0] + b_sh[15:0]};
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            byte_sum[8*i+:8] = a_sh[8*i+:8] + b_sh[8*i+:8];
        end
    end
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            a_sh <= '0;
            b_sh <= '0;
        end else if (take) begin
            for (int i = 0; i < BE_W; i++) begin
                if (avalon_in.byteenable[i] && avalon_in.address == OFS_FIRST_OPERAND) begin
                    a_sh[8*i+:8] <= avalon_in.writedata[8*i+:8];
                end
                if (avalon_in.byteenable[i] && avalon_in.address == OFS_SECOND_OPERAND) begin
                    b_sh[8*i+:8] <= avalon_in.writedata[8*i+:8];
                end
            end
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    AST_FLAGS_KEPT:
    assert property (fire && legal && !is_test |=> flags_out == $past(flags_out))
        else $error("flags changed by a packed arithmetic command");
    AST_V_KEPT:
    assert property (fire && legal && is_test |=> flags_out[0] == $past(flags_out[0]))
        else $error("overflow flag changed by a test command");
    AST_AND_FLAGS:
    assert property (fire && legal && c.op_code == 4'h2 |=> flags_out[3:2] == $past(and_nz))
        else $error("bit test negative or zero flag wrong");
    AST_XOR_FLAGS:
    assert property (fire && legal && c.op_code == 4'h3 |=> flags_out[3:2] == $past(xor_nz))
        else $error("equivalence test negative or zero flag wrong");
    AST_CARRY_LOAD:
    assert property (fire && legal && is_test && c.carry_valid |=>
        flags_out[1] == $past(carry_bit))
        else $error("test command did not load the carry");
    AST_TEST_NO_WRITE:
    assert property (fire && is_test |=> $stable(result_out))
        else $error("test command wrote a result");
    AST_HALF_ADD:
    assert property (fire && legal && c.op_code == 4'h4 |=> result_out == $past(half_sum))
        else $error("halfword add result wrong");
    AST_BYTE_ADD:
    assert property (fire && legal && c.op_code == 4'h5 |=> result_out == $past(byte_sum))
        else $error("byte add result wrong");
endmodule

bind simd_halfword_byte_add_sub_test_alu alu_slice_checker i_checker(.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .avalon_in(avalon_in),
    .avalon_waitrequest_out(avalon_waitrequest_out),
    .avalon_readdata_out(avalon_readdata_out), .result_out(result_out),
    .flags_out(flags_out));

// ### simd_halfword_byte_add_sub_test_alu_test.sv
// Purpose: Self-checking bench running every operation on two operand sets.
// Assumes: Expected results follow the packed lane semantics, computed here.
// Notes: Refused commands, status clear, byteenable and an unmapped read are covered.
`timescale 1ns/10ps
module simd_halfword_byte_add_sub_test_alu_test;
    import simd_alu_pkg::*;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    av_req_type req;
    logic wait_w;
    logic [DATA_W-1:0] rdata, result, a, b, t, exp_r, rd;
    logic [3:0] flags, exp_f;
    int num_errors = 0;
    int cmp_count = 0;
    always #2.5 mclk_in = ~mclk_in;
    simd_halfword_byte_add_sub_test_alu i_dut(.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .avalon_in(req), .avalon_waitrequest_out(wait_w), .avalon_readdata_out(rdata),
        .result_out(result), .flags_out(flags));
    alu_host_model i_host(.mclk_in(mclk_in), .wait_in(wait_w), .rdata_in(rdata),
        .req_out(req));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] cmd(input int op, input logic [3:0] first,
        input logic cv, input logic ci);
        return {14'h0000, cv, ci, 4'h1, first, 4'h3, op[3:0]};
    endfunction

    // Halving lanes, byte lanes included, are formed in the 17-bit h and l so the carry or borrow lands above the lane.
    function automatic logic [31:0] model(input int op, input logic [31:0] x, y, prev);
        logic [16:0] h, l;
        logic [31:0] r;
        case (op)
            0: return {x[31:16] + y[15:0], x[31:16] - y[15:0]};
            1, 7: return {x[31:16] - y[15:0], x[15:0] + y[31:16]};
            4: return {x[31:16] + y[31:16], x[15:0] + y[15:0]};
            6: return {x[31:16] + y[15:0], x[15:0] - y[31:16]};
            8, 10, 11: begin
                h = (op == 11) ? x[31:16] - y[15:0] : x[31:16] + y[(op == 8) ? 31 : 15 -: 16];
                l = (op == 10) ? x[15:0] - y[31:16] : x[15:0] + y[(op == 8) ? 15 : 31 -: 16];
                return {h[16:1], l[16:1]};
            end
            5, 9: begin
                for (int i = 0; i < 4; i++) begin
                    h = x[8*i+:8] + y[8*i+:8];
                    r[8*i+:8] = (op == 5) ? h[7:0] : h[8:1];
                end
                return r;
            end
            default: return prev;
        endcase
    endfunction

    task automatic results();
        $display("Comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #20000;
        num_errors++;
        results();
    end

    initial begin
        repeat (3) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        exp_f = 4'h0;
        exp_r = 32'h0000_0000;
        for (int s = 0; s < 2; s++) begin
            a = s ? 32'h0000_00ff : 32'h8001_ff80;
            b = s ? 32'hffff_ff00 : 32'h8003_0090;
            i_host.access(1'b1, OFS_FIRST_OPERAND, a, 4'hf, rd);
            i_host.access(1'b1, OFS_SECOND_OPERAND, b, 4'hf, rd);
            for (int op = 0; op < 12; op++) begin
                i_host.access(1'b1, OFS_COMMAND, cmd(op, 4'h2, op == 2, s[0]), 4'hf, rd);
                exp_r = model(op, a, b, exp_r);
                t = (op == 2) ? (a & b) : (a ^ b);
                if (op == 2 || op == 3) begin
                    exp_f = {t[31], t == 32'h0000_0000, (op == 2) ? s[0] : exp_f[1], exp_f[0]};
                end
                i_host.access(1'b0, OFS_RESULT, 32'h0000_0000, 4'hf, rd);
                check("result", exp_r, rd);
                check("result_out", exp_r, result);
                check("flags", {28'h0, exp_f}, {28'h0, flags});
            end
        end
        i_host.access(1'b1, OFS_STATUS_WORD, 32'h1000_0000, 4'h8, rd);
        i_host.access(1'b1, OFS_COMMAND, cmd(2, 4'h2, 1'b0, 1'b0), 4'hf, rd);
        check("flags after test", 32'h5, {28'h0, flags});
        i_host.access(1'b1, OFS_COMMAND, cmd(12, 4'h2, 1'b0, 1'b0), 4'hf, rd);
        i_host.access(1'b1, OFS_COMMAND, cmd(4, 4'hd, 1'b0, 1'b0), 4'hf, rd);
        check("refused result", exp_r, result);
        check("refused flags", 32'h5, {28'h0, flags});
        i_host.access(1'b0, OFS_COMMAND, 32'h0000_0000, 4'hf, rd);
        check("last command", cmd(4, 4'hd, 1'b0, 1'b0), rd);
        i_host.access(1'b0, OFS_STATUS_WORD, 32'h0000_0000, 4'hf, rd);
        check("status word", 32'h5000_0000, rd);
        i_host.access(1'b0, OFS_SECOND_OPERAND, 32'h0000_0000, 4'hf, rd);
        check("second operand", b, rd);
        i_host.access(1'b0, OFS_ERROR_STATUS, 32'h0000_0000, 4'hf, rd);
        check("error status", 32'h0019_0001, rd);
        i_host.access(1'b1, OFS_ERROR_STATUS, 32'h0000_0001, 4'h1, rd);
        i_host.access(1'b0, OFS_ERROR_STATUS, 32'h0000_0000, 4'hf, rd);
        check("error cleared", 32'h0019_0000, rd);
        i_host.access(1'b1, OFS_FIRST_OPERAND, 32'haabb_ccdd, 4'h5, rd);
        i_host.access(1'b0, OFS_FIRST_OPERAND, 32'h0000_0000, 4'hf, rd);
        check("byteenable write", 32'h00bb_00dd, rd);
        i_host.access(1'b0, 5'h18, 32'h0000_0000, 4'hf, rd);
        check("unmapped read", 32'h0000_0000, rd);
        results();
    end
endmodule
